// ===== rro_pkg.sv
/*
 * Shared constants and types for the return and rotate execution unit.
 * Assumes a core with an 8-bit data path, a 7-bit file address and a
 * return-address stack that presents its top entry combinationally.
 */
`default_nettype none

package rro_pkg;

    // Data path geometry
    localparam int RRO_DATA_W = 8;
    localparam int RRO_ADDR_W = 7;
    localparam int RRO_PC_W = 15;
    localparam int RRO_MSB = 7;

    // Interrupt control register: enable bit position and its set mask
    localparam int RRO_GIE_BIT = 7;
    localparam logic [RRO_DATA_W-1:0] RRO_GIE_SET_MASK = 8'h80;
    localparam logic [RRO_DATA_W-1:0] RRO_NO_SET_MASK = 8'h00;

    // Destination select values
    localparam logic RRO_DEST_ACC = 1'h0;
    localparam logic RRO_DEST_FILE = 1'h1;

    // Instruction cycle counts
    localparam int RRO_RETURN_CYCLES = 2;
    localparam int RRO_ROTATE_CYCLES = 1;

    typedef enum logic [2:0] {
        RRO_OP_NONE = 3'h0,
        RRO_OP_INTERRUPT_EXIT = 3'h1,
        RRO_OP_SUB_RETURN = 3'h2,
        RRO_OP_LITERAL_RETURN = 3'h3,
        RRO_OP_ROTATE_LEFT_CARRY = 3'h4
    } rro_op_type;

    // Gray order along ready -> second -> ready
    typedef enum logic [0:0] {
        RRO_ST_READY = 1'h0,
        RRO_ST_SECOND = 1'h1
    } rro_state_type;

    typedef struct packed {
        logic valid;
        rro_op_type op;
        logic [RRO_DATA_W-1:0] literal;
        logic [RRO_ADDR_W-1:0] addr;
        logic dest;
    } rro_issue_type;

endpackage : rro_pkg

`default_nettype wire

// ===== rro_rotate.sv
/*
 * Combinational rotate-left-through-carry of one data word.
 * Assumes the operand and carry are stable for the cycle they are used.
 */
`timescale 1ns/1ps
`default_nettype none

module rro_rotate #(
    parameter int WIDTH = rro_pkg::RRO_DATA_W
) (
    // Operand
    input wire logic [WIDTH-1:0] operand,
    input wire logic carry_in,
    // Result
    output logic [WIDTH-1:0] result,
    output logic carry_out
);
    import rro_pkg::*;

    generate
        if (WIDTH < 2) begin : g_bad_width
            $error("rro_rotate needs at least two bits");
        end
    endgenerate

    // Old carry enters bit 0, old top bit leaves as carry
    assign result = {operand[WIDTH-2:0], carry_in};
    assign carry_out = operand[WIDTH-1];

endmodule : rro_rotate

`default_nettype wire

// ===== rro_return_rotate.sv
/*
 * Execution unit for interrupt exit, subroutine return, literal return and
 * rotate-left-through-carry.
 * Assumes the decoder holds an instruction on issue until issue_ready is
 * seen high, that the stack top and the addressed file byte are valid in
 * the issue cycle, and that the core applies the registered strobes.
 */
// What this block does
// - Interrupt exit pops the stack and loads the popped top into the PC.
// - Interrupt exit sets the global interrupt enable, bit 7 of interrupt control.
// - Interrupt exit is one word, two cycles, no operands, flags untouched.
// - Subroutine return pops the stack into the PC in two cycles.
// - Literal return writes its 8-bit literal into the accumulator.
// - Literal return also loads the PC from the stack top; two cycles.
// - Rotate left moves old carry into bit 0, old bit 7 to carry only.
// - Rotate destination 0 writes the accumulator, 1 writes the addressed register.
`timescale 1ns/1ps
`default_nettype none

module rro_return_rotate #(
    parameter int PC_W = rro_pkg::RRO_PC_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Instruction issue
    input wire rro_pkg::rro_issue_type issue,
    output logic issue_ready,
    // Core state inputs
    input wire logic [PC_W-1:0] stack_top,
    input wire logic [rro_pkg::RRO_DATA_W-1:0] file_rdata,
    input wire logic carry_in,
    // Program counter and stack
    output logic stack_pop,
    output logic pc_load,
    output logic [PC_W-1:0] pc_value,
    // Accumulator write
    output logic acc_we,
    output logic [rro_pkg::RRO_DATA_W-1:0] acc_wdata,
    // Register file write
    output logic file_we,
    output logic [rro_pkg::RRO_ADDR_W-1:0] file_waddr,
    output logic [rro_pkg::RRO_DATA_W-1:0] file_wdata,
    // Carry flag write
    output logic carry_we,
    output logic carry_wdata,
    // Interrupt control register bit-set strobe
    output logic [rro_pkg::RRO_DATA_W-1:0] icr_set_mask
);
    import rro_pkg::*;

    generate
        if (PC_W < 1) begin : g_bad_pc
            $error("rro_return_rotate needs a program counter of at least one bit");
        end
        if (RRO_GIE_BIT != RRO_MSB) begin : g_bad_mask
            $error("interrupt enable mask does not match its bit position");
        end
    endgenerate

    rro_state_type state_reg;
    rro_state_type state_next;
    logic issue_ready_reg;
    logic stack_pop_reg;
    logic pc_load_reg;
    logic [PC_W-1:0] pc_value_reg;
    logic acc_we_reg;
    logic [RRO_DATA_W-1:0] acc_wdata_reg;
    logic file_we_reg;
    logic [RRO_ADDR_W-1:0] file_waddr_reg;
    logic [RRO_DATA_W-1:0] file_wdata_reg;
    logic carry_we_reg;
    logic carry_wdata_reg;
    logic [RRO_DATA_W-1:0] icr_set_mask_reg;

    // Decode of the accepted instruction
    wire logic take = issue.valid && issue_ready_reg;
    wire logic is_exit = take && (issue.op == RRO_OP_INTERRUPT_EXIT);
    wire logic is_sub = take && (issue.op == RRO_OP_SUB_RETURN);
    wire logic is_lit = take && (issue.op == RRO_OP_LITERAL_RETURN);
    wire logic is_rot = take && (issue.op == RRO_OP_ROTATE_LEFT_CARRY);
    wire logic is_ret = is_exit || is_sub || is_lit;
    wire logic rot_to_acc = is_rot && (issue.dest == RRO_DEST_ACC);
    wire logic rot_to_file = is_rot && (issue.dest == RRO_DEST_FILE);

    logic [RRO_DATA_W-1:0] rot_result;
    logic rot_carry;

    rro_rotate #(
        .WIDTH(RRO_DATA_W)
    ) u_rotate (
        .operand(file_rdata),
        .carry_in(carry_in),
        .result(rot_result),
        .carry_out(rot_carry)
    );

    // Returns hold the issue port for a second cycle; rotate never does
    always_comb begin
        case (state_reg)
            RRO_ST_READY: state_next = is_ret ? RRO_ST_SECOND : RRO_ST_READY;
            RRO_ST_SECOND: state_next = RRO_ST_READY;
            default: state_next = RRO_ST_READY;
        endcase
    end

    // Next values of the write strobes and data
    wire logic acc_we_next = is_lit || rot_to_acc;
    wire logic [RRO_DATA_W-1:0] acc_wdata_next = is_lit ? issue.literal : rot_result;
    wire logic [PC_W-1:0] pc_value_next = is_ret ? stack_top : pc_value_reg;
    wire logic [RRO_DATA_W-1:0] icr_set_mask_next = is_exit ? RRO_GIE_SET_MASK : RRO_NO_SET_MASK;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_reg <= RRO_ST_READY;
            issue_ready_reg <= 1'h1;
        end else begin
            state_reg <= state_next;
            issue_ready_reg <= (state_next == RRO_ST_READY);
        end
    end

    // Stack pop and PC reload share the return decode
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            stack_pop_reg <= 1'h0;
            pc_load_reg <= 1'h0;
            pc_value_reg <= '0;
            icr_set_mask_reg <= RRO_NO_SET_MASK;
        end else begin
            stack_pop_reg <= is_ret;
            pc_load_reg <= is_ret;
            pc_value_reg <= pc_value_next;
            icr_set_mask_reg <= icr_set_mask_next;
        end
    end

    // Data results; carry strobe only on rotate so returns keep the flags
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            acc_we_reg <= 1'h0;
            acc_wdata_reg <= '0;
            file_we_reg <= 1'h0;
            file_waddr_reg <= '0;
            file_wdata_reg <= '0;
            carry_we_reg <= 1'h0;
            carry_wdata_reg <= 1'h0;
        end else begin
            acc_we_reg <= acc_we_next;
            acc_wdata_reg <= acc_wdata_next;
            file_we_reg <= rot_to_file;
            file_waddr_reg <= is_rot ? issue.addr : file_waddr_reg;
            file_wdata_reg <= is_rot ? rot_result : file_wdata_reg;
            carry_we_reg <= is_rot;
            carry_wdata_reg <= is_rot ? rot_carry : carry_wdata_reg;
        end
    end

    assign issue_ready = issue_ready_reg;
    assign stack_pop = stack_pop_reg;
    assign pc_load = pc_load_reg;
    assign pc_value = pc_value_reg;
    assign acc_we = acc_we_reg;
    assign acc_wdata = acc_wdata_reg;
    assign file_we = file_we_reg;
    assign file_waddr = file_waddr_reg;
    assign file_wdata = file_wdata_reg;
    assign carry_we = carry_we_reg;
    assign carry_wdata = carry_wdata_reg;
    assign icr_set_mask = icr_set_mask_reg;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    sequence ret_issue_s;
        issue.valid && issue_ready && (issue.op inside {RRO_OP_INTERRUPT_EXIT, RRO_OP_SUB_RETURN,
            RRO_OP_LITERAL_RETURN});
    endsequence

    sequence rot_issue_s;
        issue.valid && issue_ready && (issue.op == RRO_OP_ROTATE_LEFT_CARRY);
    endsequence

    sequence two_cycle_s;
        !issue_ready ##1 issue_ready;
    endsequence

    return_pop_a: assert property (ret_issue_s |=> stack_pop && pc_load && pc_value == $past(stack_top))
        else $error("return did not pop the stack into the PC");

    enable_set_a: assert property (issue.valid && issue_ready && issue.op == RRO_OP_INTERRUPT_EXIT
        |=> icr_set_mask == RRO_GIE_SET_MASK ##1 icr_set_mask == RRO_NO_SET_MASK)
        else $error("interrupt exit did not set the enable bit once");

    return_cycles_a: assert property (ret_issue_s |=> two_cycle_s)
        else $error("return did not take two cycles");

    flags_kept_a: assert property (ret_issue_s |=> !carry_we ##1 !carry_we)
        else $error("return touched the carry flag");

    literal_acc_a: assert property (issue.valid && issue_ready && issue.op == RRO_OP_LITERAL_RETURN
        |=> acc_we && acc_wdata == $past(issue.literal) && pc_load)
        else $error("literal return did not load the accumulator");

    rotate_value_a: assert property (rot_issue_s |=> carry_we && carry_wdata == $past(file_rdata[RRO_MSB])
        && (acc_we ? acc_wdata : file_wdata) == {$past(file_rdata[RRO_MSB-1:0]), $past(carry_in)})
        else $error("rotate result or carry wrong");

    rotate_dest_a: assert property (rot_issue_s |=> acc_we == !$past(issue.dest)
        && file_we == $past(issue.dest) && file_waddr == $past(issue.addr))
        else $error("rotate wrote the wrong destination");

    rotate_single_a: assert property (rot_issue_s |=> issue_ready && !stack_pop && !pc_load)
        else $error("rotate did not finish in one cycle");

endmodule : rro_return_rotate

`default_nettype wire

// ===== test_return_and_rotate_ops.sv
/*
 * Self-checking bench for the return and rotate execution unit.
 * It drives the issue port directly, 1 ns after each rising edge.
 * The stack, the register file and the carry flag are stood in by plain
 * bench signals.
 */
`timescale 1ns/1ps
`default_nettype none

module test_return_and_rotate_ops;
    import rro_pkg::*;

    localparam int PC_W = RRO_PC_W;
    // Whole run needs well under a hundred cycles
    localparam int TIMEOUT_CYCLES = 2000;

    logic clock = 1'b0;
    logic rst = 1'b1;
    rro_issue_type issue = '0;
    logic [PC_W-1:0] stack_top = '0;
    logic [RRO_DATA_W-1:0] file_rdata = 8'h00;
    logic carry_in = 1'b0;
    wire logic issue_ready, stack_pop, pc_load, acc_we, file_we, carry_we, carry_wdata;
    wire logic [PC_W-1:0] pc_value;
    wire logic [RRO_DATA_W-1:0] acc_wdata, file_wdata, icr_set_mask;
    wire logic [RRO_ADDR_W-1:0] file_waddr;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;

    rro_return_rotate #(.PC_W(PC_W)) rro_return_rotate_inst (
        .clock(clock), .rst(rst), .issue(issue), .issue_ready(issue_ready),
        .stack_top(stack_top), .file_rdata(file_rdata), .carry_in(carry_in),
        .stack_pop(stack_pop), .pc_load(pc_load), .pc_value(pc_value),
        .acc_we(acc_we), .acc_wdata(acc_wdata), .file_we(file_we),
        .file_waddr(file_waddr), .file_wdata(file_wdata), .carry_we(carry_we),
        .carry_wdata(carry_wdata), .icr_set_mask(icr_set_mask)
    );

    always #50 clock = ~clock;

    task automatic end_sim;
        $display("Comparisons %0d, mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : end_sim

    always @(posedge clock) begin
        cycles++;
        if (cycles == TIMEOUT_CYCLES) begin
            mismatches++;
            $display("Error at %0t: run did not finish in time", $time);
            end_sim;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : check

    task automatic next_edge;
        @(posedge clock);
        #1;
    endtask : next_edge

    task automatic check_idle;
        check(stack_pop, 1'b0, "stack pop idle");
        check(pc_load, 1'b0, "pc load idle");
        check(acc_we, 1'b0, "acc write idle");
        check(file_we, 1'b0, "file write idle");
        check(carry_we, 1'b0, "carry write idle");
        check(icr_set_mask, RRO_NO_SET_MASK, "enable mask idle");
        check(issue_ready, 1'b1, "ready when idle");
    endtask : check_idle

    // An empty op is taken and must do nothing
    task automatic run_no_op;
        issue.valid = 1'b0;
        next_edge;
        check_idle;
        issue.valid = 1'b1;
        issue.op = RRO_OP_NONE;
        next_edge;
        check_idle;
    endtask : run_no_op

    // Reset in mid-run clears the held PC value
    task automatic run_mid_reset;
        issue.valid = 1'b0;
        rst = 1'b1;
        next_edge;
        check_idle;
        check(pc_value, '0, "pc value reset");
        rst = 1'b0;
    endtask : run_mid_reset

    // Return, then a rotate offered in the busy cycle must be ignored
    task automatic run_return(input rro_op_type op, input logic [7:0] lit, input logic [PC_W-1:0] top);
        issue.valid = 1'b1;
        issue.op = op;
        issue.literal = lit;
        issue.addr = 7'h55;
        issue.dest = RRO_DEST_FILE;
        stack_top = top;
        carry_in = 1'b1;
        file_rdata = 8'hFF;
        next_edge;
        stack_top = ~top;
        check(stack_pop, 1'b1, "stack pop");
        check(pc_load, 1'b1, "pc load");
        check(pc_value, top, "pc value");
        check(icr_set_mask, (op == RRO_OP_INTERRUPT_EXIT) ? RRO_GIE_SET_MASK : RRO_NO_SET_MASK, "enable mask");
        check(acc_we, op == RRO_OP_LITERAL_RETURN, "acc write");
        if (op == RRO_OP_LITERAL_RETURN) begin
            check(acc_wdata, lit, "acc literal");
        end
        check(carry_we, 1'b0, "flags kept");
        check(file_we, 1'b0, "no file write");
        check(issue_ready, 1'b0, "second cycle busy");
        issue.op = RRO_OP_ROTATE_LEFT_CARRY;
        next_edge;
        check_idle;
        check(pc_value, top, "pc value held");
    endtask : run_return

    // Leaves the request up so rotates run back to back
    task automatic run_rotate(input logic [7:0] data, input logic c, input logic dest, input logic [6:0] addr);
        logic [7:0] res;
        res = {data[6:0], c};
        issue.valid = 1'b1;
        issue.op = RRO_OP_ROTATE_LEFT_CARRY;
        issue.literal = 8'h00;
        issue.addr = addr;
        issue.dest = dest;
        file_rdata = data;
        carry_in = c;
        next_edge;
        check(carry_we, 1'b1, "carry write");
        check(carry_wdata, data[7], "carry out");
        check(acc_we, dest == RRO_DEST_ACC, "acc dest");
        check(file_we, dest == RRO_DEST_FILE, "file dest");
        if (dest == RRO_DEST_ACC) begin
            check(acc_wdata, res, "acc result");
        end else begin
            check(file_wdata, res, "file result");
            check(file_waddr, addr, "file address");
        end
        check(stack_pop, 1'b0, "no pop on rotate");
        check(icr_set_mask, RRO_NO_SET_MASK, "no mask on rotate");
        check(issue_ready, 1'b1, "single cycle");
    endtask : run_rotate

    initial begin
        repeat (8) @(posedge clock);
        #1;
        check_idle;
        rst = 1'b0;
        run_return(RRO_OP_INTERRUPT_EXIT, 8'h00, 15'h7FFF);
        run_return(RRO_OP_SUB_RETURN, 8'h3C, 15'h0000);
        run_return(RRO_OP_LITERAL_RETURN, 8'hFF, 15'h2AAA);
        run_return(RRO_OP_LITERAL_RETURN, 8'h00, 15'h5555);
        run_rotate(8'h80, 1'b0, RRO_DEST_ACC, 7'h00);
        run_rotate(8'h01, 1'b1, RRO_DEST_FILE, 7'h7F);
        run_rotate(8'hA5, 1'b1, RRO_DEST_ACC, 7'h12);
        run_rotate(8'h5A, 1'b0, RRO_DEST_FILE, 7'h40);
        run_no_op;
        // A return must still work right after a mid-run reset
        run_mid_reset;
        run_return(RRO_OP_INTERRUPT_EXIT, 8'h11, 15'h1234);
        end_sim;
    end

endmodule : test_return_and_rotate_ops

`default_nettype wire
